// ---- hdl/sbm_pkg.sv ----
//------------------------------------------------------------------------------
// Purpose: Shared constants and types of the synchronous burst memory port
// Assumes: Word-aligned register map, 32-bit register data
// Notes:   Field positions follow the struct layouts below
//------------------------------------------------------------------------------
package sbm_pkg;

	// Widths and counts
	localparam int DATA_W = 32;
	localparam int ADDR_W = 20;
	localparam int SPACES = 4;
	localparam int REG_ADDR_W = 6;
	localparam int FIFO_DEPTH = 32;
	localparam int MAX_LAT = 3;

	// Register byte offsets
	localparam logic [5:0] OFF_SEC0 = 6'h00;
	localparam logic [5:0] OFF_SEC1 = 6'h04;
	localparam logic [5:0] OFF_SEC2 = 6'h08;
	localparam logic [5:0] OFF_SEC3 = 6'h0C;
	localparam logic [5:0] OFF_ADDR = 6'h10;
	localparam logic [5:0] OFF_WDATA = 6'h14;
	localparam logic [5:0] OFF_CMD = 6'h18;
	localparam logic [5:0] OFF_STATUS = 6'h1C;
	localparam logic [5:0] OFF_RDATA = 6'h20;

	// Space control fields: read latency [1:0], write latency [3:2],
	// chip enable extend [4], strobe function [5], clock select [6]
	localparam int SEC_W = 7;
	localparam logic [6:0] SEC_RESET = 7'h00;

	// Command fields: space [1:0], write [2], burst length minus one [5:3]
	localparam int CMD_W = 6;

	// Status fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_FULL_BIT = 1;
	localparam int ST_EMPTY_BIT = 2;
	localparam int ST_PEND_BIT = 3;
	localparam int ST_COUNT_LSB = 8;
	localparam int ST_BEATS_LSB = 16;

	typedef struct packed {
		logic clkSel;
		logic strobeSel;
		logic ceExtend;
		logic [1:0] writeLat;
		logic [1:0] readLat;
	} sbm_space_cfg_s;

	typedef struct packed {
		logic [2:0] lenM1;
		logic write;
		logic [1:0] space;
	} sbm_cmd_s;

	typedef struct packed {
		logic [SPACES-1:0] chipEnableN;
		logic strobeN;
		logic outputEnableN;
		logic writeEnableN;
	} sbm_pins_s;

	localparam sbm_pins_s PINS_IDLE = '{chipEnableN: 4'hF, strobeN: 1'b1,
		outputEnableN: 1'b1, writeEnableN: 1'b1};

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ISSUE,
		ST_DRAIN,
		ST_DESEL
	} sbm_state_e;

endpackage

// ---- hdl/sbm_mem.sv ----
//------------------------------------------------------------------------------
// Purpose: Small two-port word memory with registered read data
// Assumes: One write and one read port on the same clock
// Notes:   A write to the address being read is passed straight through
//------------------------------------------------------------------------------
module sbm_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32,
	parameter int AW = $clog2(DEPTH)
) (
	// Clock
	input wire logic clk,
	input wire logic clkEn,
	// Write port
	input wire logic writeEn,
	input wire logic [AW-1:0] writeAddr,
	input wire logic [WIDTH-1:0] writeData,
	// Read port
	input wire logic [AW-1:0] readAddr,
	output logic [WIDTH-1:0] readData
);

	logic [WIDTH-1:0] store [DEPTH];

	// Storage write
	always_ff @(posedge clk) begin
		if (clkEn && writeEn) begin
			store[writeAddr] <= writeData;
		end
	end

	// Registered read with write bypass
	always_ff @(posedge clk) begin
		if (clkEn) begin
			if (writeEn && writeAddr == readAddr) begin
				readData <= writeData;
			end else begin
				readData <= store[readAddr];
			end
		end
	end

endmodule

// ---- hdl/sbm_fifo.sv ----
//------------------------------------------------------------------------------
// Purpose: Valid/ready FIFO holding write data for the memory port
// Assumes: Depth is a power of two
// Notes:   Output word is valid in the cycle after it becomes the oldest
//------------------------------------------------------------------------------
module sbm_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	// Filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	// Fill level
	output logic [$clog2(DEPTH):0] count
);

	localparam int AW = $clog2(DEPTH);

	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	logic [AW:0] rdPtr_d;
	logic push;
	logic pop;
	logic outValid_q;

	// Elaboration check on the depth
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gDepthCheck
		$error("sbm_fifo: DEPTH must be a power of two, at least 2");
	end

	assign count = wrPtr_q - rdPtr_q;
	assign inReady = count != DEPTH[AW:0];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign rdPtr_d = rdPtr_q + {{AW{1'b0}}, pop};
	assign outValid = outValid_q;

	// Pointers
	always_ff @(posedge clk) begin
		if (reset) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else if (clkEn) begin
			wrPtr_q <= wrPtr_q + {{AW{1'b0}}, push};
			rdPtr_q <= rdPtr_d;
		end
	end

	// Output valid is registered at the same edge as the memory read data
	always_ff @(posedge clk) begin
		if (reset) begin
			outValid_q <= 1'b0;
		end else if (clkEn) begin
			outValid_q <= (wrPtr_q != rdPtr_d) || (push && !pop
				&& wrPtr_q == rdPtr_q) ? (wrPtr_q != rdPtr_d) : 1'b0;
		end
	end

	sbm_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) uMem (
		.clk(clk),
		.clkEn(clkEn),
		.writeEn(push),
		.writeAddr(wrPtr_q[AW-1:0]),
		.writeData(inData),
		.readAddr(rdPtr_d[AW-1:0]),
		.readData(outData)
	);

endmodule

// ---- hdl/sbm_sync_if.sv ----
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
// Purpose: Synchronous burst SRAM / ZBT / FIFO port engine with registers
// Assumes: Memory output clocks are free-running inputs slower than clk
// Notes:   All pin outputs change only at a detected memory clock edge
//------------------------------------------------------------------------------
//
// The implementer's own choices: the strobed register port and the address map.
module sbm_sync_if
	import sbm_pkg::*;
#(
	parameter int FIFO_WORDS = sbm_pkg::FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	// Register port
	input wire logic [sbm_pkg::REG_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	// Memory clocks from the clock generator
	input wire logic memClockOut1,
	input wire logic memClockOut2,
	// Memory control pins
	output sbm_pkg::sbm_pins_s syncPins,
	output logic [sbm_pkg::ADDR_W-1:0] memAddr,
	// Memory data pins
	output logic [sbm_pkg::DATA_W-1:0] memDataOut,
	output logic memDataOe,
	input wire logic [sbm_pkg::DATA_W-1:0] memDataIn
);

	import sbm_pkg::*;

	if (FIFO_WORDS < 8 || FIFO_WORDS > 64) begin : gWordsCheck
		$error("sbm_sync_if: FIFO_WORDS must lie between 8 and 64");
	end

	localparam int CW = $clog2(FIFO_WORDS) + 1;

	//--------------------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------------------
	sbm_space_cfg_s spaceCfg_q [SPACES];
	sbm_space_cfg_s cfg;
	sbm_cmd_s cmd_q;
	sbm_state_e state_q;
	logic cmdPending_q;
	logic [ADDR_W-1:0] baseAddr_q;
	logic [2:0] beatIdx_q;
	logic [3:0] cmdLeft_q;
	logic [3:0] dataLeft_q;
	logic [3:1] pipe_q;
	logic [1:0] lat;
	logic beatNow;
	logic dataBeat;
	logic lastData;
	logic tick;
	logic [2:0] clk1Sync_q;
	logic [2:0] clk2Sync_q;
	logic [DATA_W-1:0] dataSync1_q;
	logic [DATA_W-1:0] dataSync2_q;
	logic [DATA_W-1:0] readWord_q;
	logic [3:0] readBeats_q;
	logic [31:0] regRdata_q;
	sbm_pins_s pins_q;
	sbm_pins_s pins_d;
	logic [ADDR_W-1:0] memAddr_q;
	logic [DATA_W-1:0] memDataOut_q;
	logic memDataOe_q;
	logic fifoInValid;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoOutReady;
	logic [DATA_W-1:0] fifoOutData;
	logic [CW-1:0] fifoCount;
	logic [CW-1:0] burstLen;
	logic startOk;
	logic enterIssue;
	logic [31:0] statusWord;

	assign regRdata = regRdata_q;
	assign syncPins = pins_q;
	assign memAddr = memAddr_q;
	assign memDataOut = memDataOut_q;
	assign memDataOe = memDataOe_q;

	//--------------------------------------------------------------------------
	// Memory clock edge detection
	//--------------------------------------------------------------------------
	// Two-stage synchronisers; the third stage only feeds the edge compare
	always_ff @(posedge clk) begin
		if (reset) begin
			clk1Sync_q <= 3'h0;
			clk2Sync_q <= 3'h0;
		end else if (clkEn) begin
			clk1Sync_q <= {clk1Sync_q[1:0], memClockOut1};
			clk2Sync_q <= {clk2Sync_q[1:0], memClockOut2};
		end
	end

	// The space being served (or about to be) picks its memory clock
	assign cfg = spaceCfg_q[cmd_q.space];
	assign tick = cfg.clkSel ? (clk2Sync_q[1] && !clk2Sync_q[2])
		: (clk1Sync_q[1] && !clk1Sync_q[2]);

	// Read data bus synchroniser
	always_ff @(posedge clk) begin
		if (reset) begin
			dataSync1_q <= '0;
			dataSync2_q <= '0;
		end else if (clkEn) begin
			dataSync1_q <= memDataIn;
			dataSync2_q <= dataSync1_q;
		end
	end

	//--------------------------------------------------------------------------
	// Register port
	//--------------------------------------------------------------------------
	// Space control registers
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < SPACES; i++) begin
				spaceCfg_q[i] <= sbm_space_cfg_s'(SEC_RESET);
			end
		end else if (clkEn && regWrite && regAddr[5:4] == OFF_SEC0[5:4]
			&& regAddr[1:0] == 2'h0) begin
			spaceCfg_q[regAddr[3:2]] <= sbm_space_cfg_s'(regWdata[SEC_W-1:0]);
		end
	end

	// Base address register
	always_ff @(posedge clk) begin
		if (reset) begin
			baseAddr_q <= '0;
		end else if (clkEn && regWrite && regAddr == OFF_ADDR) begin
			baseAddr_q <= regWdata[ADDR_W-1:0];
		end
	end

	// Command register; a command written while one is held is dropped
	always_ff @(posedge clk) begin
		if (reset) begin
			cmd_q <= '0;
			cmdPending_q <= 1'b0;
		end else if (clkEn) begin
			if (regWrite && regAddr == OFF_CMD && !cmdPending_q
				&& state_q == ST_IDLE) begin
				cmd_q <= sbm_cmd_s'(regWdata[CMD_W-1:0]);
				cmdPending_q <= 1'b1;
			end else if (enterIssue) begin
				cmdPending_q <= 1'b0;
			end
		end
	end

	// Write data words go into the FIFO; a full FIFO drops the word
	assign fifoInValid = regWrite && regAddr == OFF_WDATA;

	assign statusWord = {{(32 - ST_BEATS_LSB - 4){1'b0}}, readBeats_q,
		{(ST_BEATS_LSB - ST_COUNT_LSB - CW){1'b0}}, fifoCount,
		{(ST_COUNT_LSB - ST_PEND_BIT - 1){1'b0}}, cmdPending_q,
		!fifoOutValid && fifoCount == '0, !fifoInReady,
		state_q != ST_IDLE};

	// Read data stand for one cycle only; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (reset) begin
			regRdata_q <= '0;
		end else if (clkEn) begin
			regRdata_q <= '0;
			if (regRead) begin
				unique case (regAddr)
					OFF_SEC0, OFF_SEC1, OFF_SEC2, OFF_SEC3: begin
						regRdata_q <= {{(32 - SEC_W){1'b0}},
							spaceCfg_q[regAddr[3:2]]};
					end
					OFF_ADDR: regRdata_q <= {{(32 - ADDR_W){1'b0}}, baseAddr_q};
					OFF_CMD: regRdata_q <= {{(32 - CMD_W){1'b0}}, cmd_q};
					OFF_STATUS: regRdata_q <= statusWord;
					OFF_RDATA: regRdata_q <= readWord_q;
					default: regRdata_q <= '0;
				endcase
			end
		end
	end

	//--------------------------------------------------------------------------
	// Write data FIFO
	//--------------------------------------------------------------------------
	sbm_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_WORDS)) uFifo (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.inData(regWdata),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData),
		.count(fifoCount)
	);

	//--------------------------------------------------------------------------
	// Burst engine
	//--------------------------------------------------------------------------
	assign burstLen = CW'(cmd_q.lenM1) + CW'(1);
	// A write waits until its whole burst sits in the FIFO
	assign startOk = cmdPending_q && (!cmd_q.write || fifoCount >= burstLen);
	assign enterIssue = tick && state_q == ST_IDLE && startOk;

	// Latency of the current direction, in memory clock edges
	assign lat = cmd_q.write ? cfg.writeLat : cfg.readLat;
	assign beatNow = state_q == ST_ISSUE;
	// Data beat lags its command by the latency count of edges; a read of
	// latency zero is answered inside the command period, so it is taken
	// at the next edge, once the synchronised data bus has caught up
	assign dataBeat = (lat != 2'd0) ? pipe_q[lat]
		: (cmd_q.write ? beatNow : pipe_q[1]);
	assign lastData = dataBeat && dataLeft_q == 4'd1;
	assign fifoOutReady = tick && dataBeat && cmd_q.write;

	// Command delay line, shifted once per selected memory clock edge
	always_ff @(posedge clk) begin
		if (reset) begin
			pipe_q <= '0;
		end else if (clkEn && tick) begin
			pipe_q <= {pipe_q[2:1], beatNow};
		end
	end

	// Sequence state
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
		end else if (clkEn && tick) begin
			unique case (state_q)
				ST_IDLE: begin
					if (startOk) begin
						state_q <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					if (cmdLeft_q == 4'd1) begin
						if (!lastData) begin
							state_q <= ST_DRAIN;
						end else if (!cfg.strobeSel) begin
							state_q <= ST_DESEL;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_DRAIN: begin
					if (lastData) begin
						state_q <= cfg.strobeSel ? ST_IDLE : ST_DESEL;
					end
				end
				ST_DESEL: state_q <= ST_IDLE;
			endcase
		end
	end

	// Beat counters and address index
	always_ff @(posedge clk) begin
		if (reset) begin
			cmdLeft_q <= '0;
			dataLeft_q <= '0;
			beatIdx_q <= '0;
		end else if (clkEn && tick) begin
			if (enterIssue) begin
				cmdLeft_q <= {1'b0, cmd_q.lenM1} + 4'd1;
				dataLeft_q <= {1'b0, cmd_q.lenM1} + 4'd1;
				beatIdx_q <= '0;
			end else begin
				if (beatNow) begin
					cmdLeft_q <= cmdLeft_q - 4'd1;
					beatIdx_q <= beatIdx_q + 3'd1;
				end
				if (dataBeat) begin
					dataLeft_q <= dataLeft_q - 4'd1;
				end
			end
		end
	end

	// Read capture at each read data beat
	always_ff @(posedge clk) begin
		if (reset) begin
			readWord_q <= '0;
			readBeats_q <= '0;
		end else if (clkEn && tick) begin
			if (enterIssue && !cmd_q.write) begin
				readBeats_q <= '0;
			end else if (dataBeat && !cmd_q.write) begin
				readWord_q <= dataSync2_q;
				readBeats_q <= readBeats_q + 4'd1;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Pin drive
	//--------------------------------------------------------------------------
	// Pin levels for the memory clock period that follows this edge
	always_comb begin
		pins_d = PINS_IDLE;
		if (beatNow) begin
			pins_d.chipEnableN[cmd_q.space] = 1'b0;
			// Strobe pin: address strobe or FIFO read enable
			pins_d.strobeN = cfg.strobeSel ? cmd_q.write : 1'b0;
			pins_d.writeEnableN = !cmd_q.write;
		end
		if (!cmd_q.write && (beatNow || state_q == ST_DRAIN)) begin
			pins_d.outputEnableN = 1'b0;
			if (cfg.ceExtend) begin
				pins_d.chipEnableN[cmd_q.space] = 1'b0;
			end
		end
		if (state_q == ST_DESEL) begin
			pins_d.strobeN = 1'b0;
		end
	end

	// Control pins and address, both registered at the edge
	always_ff @(posedge clk) begin
		if (reset) begin
			pins_q <= PINS_IDLE;
			memAddr_q <= '0;
		end else if (clkEn && tick) begin
			pins_q <= pins_d;
			if (beatNow) begin
				memAddr_q <= baseAddr_q + ADDR_W'(beatIdx_q);
			end
		end
	end

	// Write data driven on the data beat, bus released otherwise
	always_ff @(posedge clk) begin
		if (reset) begin
			memDataOut_q <= '0;
			memDataOe_q <= 1'b0;
		end else if (clkEn && tick) begin
			memDataOe_q <= dataBeat && cmd_q.write;
			if (dataBeat && cmd_q.write) begin
				memDataOut_q <= fifoOutData;
			end
		end
	end

endmodule

// ---- tb/sbm_sync_if_sva.sv ----
// Purpose: Pin protocol checks on the synchronous memory port
// Assumes: Space settings follow the register writes seen at the port
// Notes:   Memory clock 1 is 8 clk periods, clock 2 is 12 in the bench
module sbm_sync_if_sva
	import sbm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	// Register port
	input wire logic [sbm_pkg::REG_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regRdata,
	// Memory side
	input wire logic memClockOut1,
	input wire logic memClockOut2,
	input wire sbm_pkg::sbm_pins_s syncPins,
	input wire logic [sbm_pkg::ADDR_W-1:0] memAddr,
	input wire logic [sbm_pkg::DATA_W-1:0] memDataOut,
	input wire logic memDataOe,
	input wire logic [sbm_pkg::DATA_W-1:0] memDataIn
);
	timeunit 1ns;
	timeprecision 1ps;
	sbm_space_cfg_s cfg_q [SPACES];
	sbm_space_cfg_s cur;
	logic [1:0] space_q;
	logic [5:0] weCnt_q;
	logic [3:0] tickCnt_q;
	logic selClk;
	logic selPrev_q;
	int per;
	// ----------
	// Shadow of the settings of the commanded space
	// ----------
	assign cur = cfg_q[space_q];
	assign selClk = cur.clkSel ? memClockOut2 : memClockOut1;
	assign per = cur.clkSel ? 12 : 8;
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_q <= '{default: '0};
			space_q <= 2'h0;
		end else if (regWrite && clkEn) begin
			if (regAddr < OFF_ADDR) cfg_q[regAddr[3:2]] <= regWdata[6:0];
			if (regAddr == OFF_CMD) space_q <= regWdata[1:0];
		end
	end
	// Clocks since the first write command beat
	always_ff @(posedge clk) begin
		if (reset) weCnt_q <= 6'h00;
		else if ($fell(syncPins.writeEnableN)) weCnt_q <= 6'h01;
		else if (weCnt_q != 6'h00 && weCnt_q != 6'h3F) weCnt_q <= weCnt_q + 6'h01;
	end
	// Clocks since the selected memory clock rose
	always_ff @(posedge clk) begin
		selPrev_q <= selClk;
		if (reset || (selClk && !selPrev_q)) tickCnt_q <= 4'h0;
		else if (tickCnt_q != 4'hF) tickCnt_q <= tickCnt_q + 4'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_ONE_SPACE: assert property ($countones(~syncPins.chipEnableN) <= 1)
		else $error("two chip enables low");
	AST_WE_OE: assert property (!syncPins.writeEnableN |-> syncPins.outputEnableN)
		else $error("write and output enable low together");
	AST_EXT_CE: assert property (cur.ceExtend && !syncPins.outputEnableN |-> !syncPins.chipEnableN[space_q])
		else $error("chip enable high while output enable low");
	AST_CE_CMD: assert property (!cur.ceExtend && !(&syncPins.chipEnableN) |-> !syncPins.strobeN || !syncPins.writeEnableN)
		else $error("chip enable low without a command");
	AST_DESELECT: assert property ($rose(&syncPins.chipEnableN)
		&& !cur.strobeSel |-> ##[0:48] (&syncPins.chipEnableN
		&& !syncPins.strobeN) ##[1:14] syncPins.strobeN)
		else $error("deselect cycle missing");
	AST_NO_DESEL: assert property (cur.strobeSel
		&& &syncPins.chipEnableN |-> syncPins.strobeN)
		else $error("deselect cycle in read enable mode");
	AST_SRE_READ: assert property (cur.strobeSel && !syncPins.strobeN |-> !syncPins.outputEnableN)
		else $error("read enable outside a read");
	AST_WR_LAT: assert property ($rose(memDataOe) |-> (cur.writeLat == 2'h0) ? $fell(syncPins.writeEnableN) : (weCnt_q >= per * cur.writeLat - 1 && weCnt_q <= per * cur.writeLat + 1))
		else $error("write data beat off its latency");
	AST_TICK: assert property (!$stable(syncPins) |-> tickCnt_q inside {[1:4]})
		else $error("pins moved off the selected clock");
	cover property ($rose(memDataOe));
	cover property ($rose(&syncPins.chipEnableN) && !syncPins.strobeN);
	cover property (cur.ceExtend && !syncPins.outputEnableN);
endmodule
bind sbm_sync_if sbm_sync_if_sva u_sva (.clk(clk), .reset(reset),
	.clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
	.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
	.memClockOut1(memClockOut1), .memClockOut2(memClockOut2),
	.syncPins(syncPins), .memAddr(memAddr), .memDataOut(memDataOut),
	.memDataOe(memDataOe), .memDataIn(memDataIn));

// ---- tb/sbm_ram_model.sv ----
// Purpose: Behavioural synchronous burst memory on the far side
// Assumes: One space active at a time, its clock and latency given
// Notes:   Data bus shows inverted garbage outside its valid window
module sbm_ram_model
	import sbm_pkg::*;
(
	// Clocks and settings of the active space
	input wire logic memClockOut1,
	input wire logic memClockOut2,
	input wire logic clkSel,
	input wire logic [1:0] readLat,
	// Pins from the port
	input wire sbm_pkg::sbm_pins_s syncPins,
	input wire logic [sbm_pkg::ADDR_W-1:0] memAddr,
	input wire logic [sbm_pkg::DATA_W-1:0] memDataOut,
	input wire logic memDataOe,
	output logic [sbm_pkg::DATA_W-1:0] memDataIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [2048];
	logic [10:0] wq [$];
	logic [10:0] rp [4];
	logic [3:0] rv = 4'h0;
	logic [31:0] pipeOut = 32'h0;
	logic mclk;
	logic sel;
	logic rdCmd;
	// ----------
	// Command decode and data pipeline
	// ----------
	assign mclk = clkSel ? memClockOut2 : memClockOut1;
	assign sel = !(&syncPins.chipEnableN);
	assign rdCmd = sel && !syncPins.strobeN && syncPins.writeEnableN;
	assign memDataIn = (readLat == 2'h0 && rdCmd) ? mem[memAddr[10:0]] : pipeOut;
	always @(posedge mclk) begin
		if (sel && !syncPins.writeEnableN) wq.push_back(memAddr[10:0]);
		if (memDataOe && wq.size() > 0) mem[wq.pop_front()] = memDataOut;
		rv = rv >> 1;
		for (int j = 0; j < 3; j++) rp[j] = rp[j + 1];
		// Data valid at the edge readLat after the command edge
		if (rdCmd && readLat != 2'h0) begin
			rp[readLat - 1] = memAddr[10:0];
			rv[readLat - 1] = 1'b1;
		end
		pipeOut = rv[0] ? mem[rp[0]] : ~pipeOut;
	end
endmodule

// ---- tb/test_sbm_sync_if.sv ----
// Purpose: Register driven bursts through the synchronous memory port
// Assumes: Register map and status layout of sbm_pkg
// Notes:   Memory clocks run free, unrelated in phase to clk
module test_sbm_sync_if;
	timeunit 1ns;
	timeprecision 1ps;
	import sbm_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clkEn = 1'b1;
	logic [5:0] regAddr = 6'h00;
	logic [31:0] regWdata = 32'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdata;
	logic memClockOut1 = 1'b0;
	logic memClockOut2 = 1'b0;
	sbm_pins_s syncPins;
	logic [ADDR_W-1:0] memAddr;
	logic [DATA_W-1:0] memDataOut;
	logic [DATA_W-1:0] memDataIn;
	logic memDataOe;
	logic mdlSel = 1'b0;
	logic [1:0] mdlRl = 2'h0;
	int mismatches = 0;
	int checkCount = 0;
	// ----------
	// Clocks, design and memory
	// ----------
	always #10 clk = ~clk;
	initial #7 forever #80 memClockOut1 = ~memClockOut1;
	initial #3 forever #120 memClockOut2 = ~memClockOut2;
	sbm_sync_if DUT (.clk(clk), .reset(reset), .clkEn(clkEn),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .memClockOut1(memClockOut1),
		.memClockOut2(memClockOut2), .syncPins(syncPins), .memAddr(memAddr),
		.memDataOut(memDataOut), .memDataOe(memDataOe), .memDataIn(memDataIn));
	sbm_ram_model ram (.memClockOut1(memClockOut1),
		.memClockOut2(memClockOut2), .clkSel(mdlSel), .readLat(mdlRl),
		.syncPins(syncPins), .memAddr(memAddr), .memDataOut(memDataOut),
		.memDataOe(memDataOe), .memDataIn(memDataIn));
	// ----------
	// Access tasks
	// ----------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t ns: seen %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask
	// Start a burst and poll status until the engine is idle
	task automatic burst(input int sp, input logic w, input int len, input int b);
		logic [31:0] s;
		int n = 0;
		wr(OFF_ADDR, {12'h000, 20'(b)});
		wr(OFF_CMD, {26'h0, 3'(len - 1), w, 2'(sp)});
		do begin
			rd(OFF_STATUS, s);
			n++;
		end while ((s[ST_BUSY_BIT] !== 1'b0 || s[ST_PEND_BIT] !== 1'b0)
			&& n < 500);
		if (n >= 500) mismatches++;
		// Let the last write beat reach the memory before it is looked at
		repeat (16) @(posedge clk);
	endtask
	task automatic results();
		if (mismatches == 0 && checkCount > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#1_500_000;
		mismatches++;
		results();
	end
	// ----------
	// Tests
	// ----------
	initial begin
		logic [31:0] d;
		sbm_space_cfg_s c;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		#1 chk({25'h0, syncPins}, {25'h0, PINS_IDLE});
		for (int i = 0; i < 5; i++) begin
			rd(6'(4 * i + (i / 4) * 44), d);
			chk(d, 32'h0);
		end
		rd(OFF_STATUS, d);
		chk(d, 32'h4);
		// A frozen block ignores a register write
		@(posedge clk) clkEn <= 1'b0;
		wr(OFF_SEC0, 32'h0000_007F);
		clkEn <= 1'b1;
		rd(OFF_SEC0, d);
		chk(d, 32'h0);
		// Every strobe and extend mix, each latency and both clocks
		for (int i = 0; i < 4; i++) begin
			c = '{clkSel: i[0], strobeSel: i[1], ceExtend: i[0] ^ i[1],
				writeLat: 2'(i), readLat: 2'(3 - i)};
			wr(6'(4 * i), {25'h0, c});
			rd(6'(4 * i), d);
			chk(d, {25'h0, c});
			mdlSel = c.clkSel;
			mdlRl = c.readLat;
			for (int k = 0; k < i + 2; k++) wr(OFF_WDATA, 32'hA500_0000 + 32'(16 * i + k));
			burst(i, 1'b1, i + 2, 256 * (i + 1));
			for (int k = 0; k < i + 2; k++) begin
				chk(ram.mem[11'(256 * (i + 1) + k)], 32'hA500_0000 + 32'(16 * i + k));
			end
			burst(i, 1'b0, i + 2, 256 * (i + 1));
			rd(OFF_RDATA, d);
			chk(d, 32'hA500_0000 + 32'(17 * i + 1));
			rd(OFF_STATUS, d);
			chk(d, (32'(i + 2) << 16) | 32'h4);
		end
		// Fill past full, then drain in four bursts of eight
		for (int k = 0; k <= FIFO_DEPTH; k++) wr(OFF_WDATA, 32'h5A00_0000 + 32'(k));
		rd(OFF_STATUS, d);
		chk({18'h0, d[13:0]}, 32'h2002);
		mdlSel = 1'b0;
		for (int b = 0; b < 4; b++) burst(0, 1'b1, 8, 32'h600 + 8 * b);
		chk(ram.mem[11'h600], 32'h5A00_0000);
		chk(ram.mem[11'h61F], 32'h5A00_001F);
		rd(OFF_STATUS, d);
		chk({18'h0, d[13:0]}, 32'h4);
		results();
	end
endmodule
